// ===== design/t1ra_top.sv
// t1 receive alarm detectors with real-time, latched and mask registers
// Contract
// (RULE1) status bit is 1 when event occurred
// (RULE2) real-time bits read-only, reads leave latches alone
// (RULE3) read data held stable during access
// (RULE4) latched bit stays set until cleared
// (RULE5) write one clears, zero leaves bit
// (RULE6) cleared bit sets only on new event
// (RULE7) unmasked latched event drives interrupt low
// (RULE8) interrupt releases when no unmasked latch remains
// (RULE9) clear works while the alarm persists
// (RULE10) frame-loss bit follows receiver sync loss
// (RULE11) sync loss rising edge sets latch
// (RULE12) sync regain falling edge sets latch
// (RULE13) blue clears on five zeros in 3ms
// (RULE14) d4 bit2 mode: 254 of 256 zeros
// (RULE15) d4 12th f-bit: two consecutive equal values
// (RULE16) esf: 16 00FF patterns set, 14 clear
// (RULE17) signal loss after 192 consecutive zeros
// (RULE18) signal loss clears: 14 ones in 112
// (RULE19) blue ignores framed ones, tolerates errors
// (RULE20) host qualifies blue with frame loss
// (RULE21) framer n registers offset by (n-1)*200h
// (RULE22) blue sets below five zeros in window
`timescale 1ns/100ps
module t1ra_top #(
  parameter int FRAMER_N = 1,
  parameter int BLUE_WIN = t1ra_pkg::BLUE_WIN_BITS
) (
  input  wire logic                         clk,
  input  wire logic                         nrst,
  input  wire t1ra_pkg::t1ra_line_t         line,
  input  wire logic [t1ra_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output      logic                         s_axi_awready,
  input  wire logic [t1ra_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output      logic                         s_axi_wready,
  output      logic [1:0]                   s_axi_bresp,
  output      logic                         s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [t1ra_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output      logic                         s_axi_arready,
  output      logic [t1ra_pkg::DATA_W-1:0]  s_axi_rdata,
  output      logic [1:0]                   s_axi_rresp,
  output      logic                         s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  output      logic                         irq_out_n
);
  localparam int BW = $clog2(BLUE_WIN + 1);
  // RULE21
  localparam logic [11:0] BASE =
    12'((FRAMER_N - 1) * int'(t1ra_pkg::FRAMER_STRIDE));

  function automatic logic [8:0] inc9(input logic [8:0] v, input logic c);
    inc9 = v + {8'h00, c};
  endfunction : inc9

  logic [3:0]  rt_reg;
  logic [3:0]  rt_prev_reg;
  logic [7:0]  lat_reg;
  logic [7:0]  lat_next;
  logic [7:0]  lat_set;
  logic [7:0]  lat_clr;
  logic [7:0]  mask_reg;
  logic [7:0]  mask_next;
  logic [1:0]  ctrl_reg;
  logic        irq_n_reg;
  logic        los_reg;
  logic [7:0]  zrun_reg;
  logic        lwin_reg;
  logic [6:0]  lwin_cnt_reg;
  logic [3:0]  lones_reg;
  logic        blue_reg;
  logic [BW-1:0] bcnt_reg;
  logic [2:0]  bzero_reg;
  logic        yel_reg;
  logic [7:0]  ych_reg;
  logic [8:0]  yz_reg;
  logic        f12_prev_reg;
  logic [4:0]  erun_reg;
  logic [3:0]  eblk_reg;
  logic [4:0]  ematch_reg;
  logic        aw_full_reg;
  logic        w_full_reg;
  logic [11:0] awaddr_reg;
  logic [7:0]  wdata_reg;
  logic        wstrb0_reg;
  logic        wr_go;
  logic        wr_hit;

  // signal loss
  always_ff @(posedge clk) begin
    if (!nrst) begin
      los_reg      <= 1'b0;
      zrun_reg     <= 8'h00;
      lwin_reg     <= 1'b0;
      lwin_cnt_reg <= 7'h00;
      lones_reg    <= 4'h0;
    end else if (line.bit_en) begin
      if (!line.bit_val) begin
        if (zrun_reg != 8'(t1ra_pkg::LOS_SET_ZEROS))
          zrun_reg <= zrun_reg + 8'h01;
        if (zrun_reg == 8'(t1ra_pkg::LOS_SET_ZEROS - 1))
          los_reg <= 1'b1; // RULE17
      end else begin
        zrun_reg <= 8'h00;
      end
      // window opens on the first one seen while in loss
      if (los_reg && !lwin_reg && line.bit_val) begin
        lwin_reg     <= 1'b1;
        lwin_cnt_reg <= 7'h01;
        lones_reg    <= 4'h1;
      end else if (los_reg && lwin_reg) begin
        lwin_cnt_reg <= lwin_cnt_reg + 7'h01;
        lones_reg    <= lones_reg + {3'h0, line.bit_val};
        if (line.bit_val &&
            lones_reg == 4'(t1ra_pkg::LOS_CLR_ONES - 1)) begin
          los_reg  <= 1'b0; // RULE18
          lwin_reg <= 1'b0;
        end else if (lwin_cnt_reg == 7'(t1ra_pkg::LOS_CLR_WIN - 1)) begin
          lwin_reg <= 1'b0;
        end
      end else if (!los_reg) begin
        lwin_reg <= 1'b0;
      end
    end
  end

  // blue alarm: a framed all-ones stream carries framing zeros in each
  // window, so it never falls below the zero threshold
  always_ff @(posedge clk) begin
    if (!nrst) begin
      blue_reg  <= 1'b0;
      bcnt_reg  <= '0;
      bzero_reg <= 3'h0;
    end else if (line.bit_en) begin
      if (bcnt_reg == BW'(BLUE_WIN - 1)) begin
        bcnt_reg  <= '0;
        bzero_reg <= 3'h0;
        // RULE13 RULE22 RULE19
        blue_reg  <= (bzero_reg + {2'h0, !line.bit_val}) <
                     3'(t1ra_pkg::BLUE_CLR_ZEROS);
      end else begin
        bcnt_reg <= bcnt_reg + BW'(1);
        if (!line.bit_val && bzero_reg != 3'(t1ra_pkg::BLUE_CLR_ZEROS))
          bzero_reg <= bzero_reg + 3'h1;
      end
    end
  end

  // yellow alarm, three framing variants
  always_ff @(posedge clk) begin
    if (!nrst) begin
      yel_reg      <= 1'b0;
      ych_reg      <= 8'h00;
      yz_reg       <= 9'h000;
      f12_prev_reg <= 1'b0;
      erun_reg     <= 5'h00;
      eblk_reg     <= 4'h0;
      ematch_reg   <= 5'h00;
    end else if (ctrl_reg[t1ra_pkg::CTRL_ESF]) begin
      if (line.fdl_en) begin
        if (!yel_reg) begin
          erun_reg <= line.fdl_match ? erun_reg + 5'h01 : 5'h00;
          if (line.fdl_match &&
              erun_reg == 5'(t1ra_pkg::YEL_ESF_PAT - 1)) begin
            yel_reg    <= 1'b1; // RULE16
            eblk_reg   <= 4'h0;
            ematch_reg <= 5'h00;
          end
        end else begin
          eblk_reg   <= eblk_reg + 4'h1;
          ematch_reg <= ematch_reg + {4'h0, line.fdl_match};
          if (eblk_reg == 4'(t1ra_pkg::YEL_ESF_PAT - 1)) begin
            ematch_reg <= 5'h00;
            if (ematch_reg + {4'h0, line.fdl_match} <=
                5'(t1ra_pkg::YEL_ESF_CLR_MAX)) begin
              yel_reg  <= 1'b0; // RULE16
              erun_reg <= 5'h00;
            end
          end
        end
      end
    end else if (ctrl_reg[t1ra_pkg::CTRL_D4_FBIT]) begin
      if (line.fbit12_en) begin
        f12_prev_reg <= line.fbit12;
        if (line.fbit12 == f12_prev_reg)
          yel_reg <= line.fbit12; // RULE15
      end
    end else if (line.ch_bit2_en) begin
      ych_reg <= ych_reg + 8'h01;
      yz_reg  <= inc9(yz_reg, !line.ch_bit2);
      if (ych_reg == 8'(t1ra_pkg::YEL_D4_CH - 1)) begin
        yz_reg  <= 9'h000;
        // RULE14
        yel_reg <= inc9(yz_reg, !line.ch_bit2) >=
                   9'(t1ra_pkg::YEL_D4_ZEROS);
      end
    end
  end

  // real-time snapshot and edge history
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rt_reg      <= 4'h0;
      rt_prev_reg <= 4'h0;
    end else begin
      rt_reg      <= {yel_reg, blue_reg, los_reg, line.frame_lost}; // RULE10
      rt_prev_reg <= rt_reg;
    end
  end

  assign lat_set = {~rt_reg & rt_prev_reg, rt_reg & ~rt_prev_reg};
  assign wr_go   = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign lat_clr = (wr_go && wstrb0_reg &&
                    awaddr_reg == BASE + t1ra_pkg::OFF_LATCHED_1) ?
                   wdata_reg : 8'h00;
  // set wins over a same-cycle clear
  assign lat_next = (lat_reg & ~lat_clr) | lat_set; // RULE5 RULE6 RULE9

  always_ff @(posedge clk) begin
    if (!nrst)
      lat_reg <= t1ra_pkg::LAT_RST;
    else
      lat_reg <= lat_next; // RULE1 RULE4 RULE11 RULE12
  end

  // a mask write reaches the interrupt in the same cycle as the register
  assign mask_next = (wr_go && wstrb0_reg &&
                      awaddr_reg == BASE + t1ra_pkg::OFF_MASK_1) ?
                     wdata_reg : mask_reg;
  always_ff @(posedge clk) begin
    if (!nrst)
      irq_n_reg <= 1'b1;
    else
      irq_n_reg <= ~|(lat_next & mask_next); // RULE7 RULE8
  end
  assign irq_out_n = irq_n_reg;

  // axi write path
  assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
  assign wr_hit = awaddr_reg == BASE + t1ra_pkg::OFF_LATCHED_1 ||
                  awaddr_reg == BASE + t1ra_pkg::OFF_MASK_1 ||
                  awaddr_reg == BASE + t1ra_pkg::OFF_REALTIME_1 ||
                  awaddr_reg == BASE + t1ra_pkg::OFF_RX_CTRL_2;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      aw_full_reg  <= 1'b0;
      w_full_reg   <= 1'b0;
      awaddr_reg   <= 12'h000;
      wdata_reg    <= 8'h00;
      wstrb0_reg   <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= t1ra_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        awaddr_reg  <= {s_axi_awaddr[11:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata[7:0];
        wstrb0_reg <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? t1ra_pkg::RESP_OKAY : t1ra_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // writes to the real-time register are ignored
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mask_reg <= t1ra_pkg::MASK_RST;
      ctrl_reg <= t1ra_pkg::CTRL_RST;
    end else if (wr_go && wstrb0_reg) begin
      if (awaddr_reg == BASE + t1ra_pkg::OFF_MASK_1)
        mask_reg <= wdata_reg;
      if (awaddr_reg == BASE + t1ra_pkg::OFF_RX_CTRL_2)
        ctrl_reg <= wdata_reg[1:0];
    end
  end

  // axi read path; data is captured once so it cannot move under the host
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= t1ra_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= t1ra_pkg::RESP_OKAY;
      unique case ({s_axi_araddr[11:2], 2'h0})
        BASE + t1ra_pkg::OFF_REALTIME_1:
          s_axi_rdata <= {28'h0000000, rt_reg}; // RULE2 RULE3
        BASE + t1ra_pkg::OFF_LATCHED_1:
          s_axi_rdata <= {24'h000000, lat_reg};
        BASE + t1ra_pkg::OFF_MASK_1:
          s_axi_rdata <= {24'h000000, mask_reg};
        BASE + t1ra_pkg::OFF_RX_CTRL_2:
          s_axi_rdata <= {30'h0000000, ctrl_reg};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= t1ra_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_clear_bit0;
    lat_reg[0] && lat_clr[0] && !lat_set[0];
  endsequence
  sequence s_unmasked;
    (lat_reg & mask_reg) != 8'h00;
  endsequence

  a_latch_sticky: assert property ( // RULE4
    lat_reg[1] && !lat_clr[1] |=> lat_reg[1])
    else $error("latched bit dropped without clear");
  a_w1c_clear: assert property ( // RULE5
    s_clear_bit0 |=> !lat_reg[0])
    else $error("write one did not clear latch");
  a_clear_persist: assert property ( // RULE9
    s_clear_bit0 ##0 rt_reg[0] && rt_prev_reg[0] |=> !lat_reg[0])
    else $error("clear failed while condition held");
  a_rise_latch: assert property ( // RULE11
    $rose(rt_reg[0]) |=> lat_reg[0])
    else $error("sync loss not latched");
  a_fall_latch: assert property ( // RULE12
    $fell(rt_reg[0]) |=> lat_reg[4])
    else $error("sync regain not latched");
  a_no_spurious: assert property ( // RULE6
    !lat_reg[2] && !lat_set[2] |=> !lat_reg[2])
    else $error("latch set without event");
  a_irq_assert: assert property ( // RULE7
    s_unmasked |-> !irq_out_n)
    else $error("interrupt not asserted");
  a_irq_release: assert property ( // RULE8
    (lat_reg & mask_reg) == 8'h00 |-> irq_out_n)
    else $error("interrupt held with no cause");
  a_frame_follow: assert property ( // RULE10
    $past(nrst) |-> rt_reg[0] == $past(line.frame_lost))
    else $error("frame loss bit not following");
  a_los_set: assert property ( // RULE17
    line.bit_en && !line.bit_val &&
    zrun_reg == 8'(t1ra_pkg::LOS_SET_ZEROS - 1) |=> los_reg)
    else $error("signal loss missed after zeros");
  a_read_stable: assert property ( // RULE3
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before taken");
endmodule : t1ra_top

// ===== design/t1ra_pkg.sv
// constants and carrier types for the t1 receive alarm status block
package t1ra_pkg;
  localparam int          ADDR_W          = 12;
  localparam int          DATA_W          = 32;
  localparam logic [11:0] FRAMER_STRIDE   = 12'h200;
  localparam logic [11:0] OFF_LATCHED_1   = 12'h090;
  localparam logic [11:0] OFF_MASK_1      = 12'h0A0;
  localparam logic [11:0] OFF_REALTIME_1  = 12'h0B0;
  localparam logic [11:0] OFF_RX_CTRL_2   = 12'h0F4;
  localparam int          RT_FRAME_LOSS   = 0;
  localparam int          RT_SIGNAL_LOSS  = 1;
  localparam int          RT_BLUE         = 2;
  localparam int          RT_YELLOW       = 3;
  localparam int          LAT_FALL_BASE   = 4;
  localparam int          CTRL_D4_FBIT    = 0;
  localparam int          CTRL_ESF        = 1;
  localparam logic [7:0]  LAT_RST         = 8'h00;
  localparam logic [7:0]  MASK_RST        = 8'h00;
  localparam logic [1:0]  CTRL_RST        = 2'h0;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
  localparam int          LOS_SET_ZEROS   = 192;
  localparam int          LOS_CLR_ONES    = 14;
  localparam int          LOS_CLR_WIN     = 112;
  localparam int          BLUE_WIN_MS     = 3;
  localparam int          LINE_RATE_BPS   = 1544000;
  localparam int          BLUE_WIN_BITS   = BLUE_WIN_MS * LINE_RATE_BPS / 1000;
  localparam int          BLUE_CLR_ZEROS  = 5;
  localparam int          YEL_D4_CH       = 256;
  localparam int          YEL_D4_ZEROS    = 254;
  localparam int          YEL_ESF_PAT     = 16;
  localparam int          YEL_ESF_CLR_MAX = 14;

  typedef struct packed {
    logic bit_en;
    logic bit_val;
    logic frame_lost;
    logic ch_bit2_en;
    logic ch_bit2;
    logic fbit12_en;
    logic fbit12;
    logic fdl_en;
    logic fdl_match;
  } t1ra_line_t;
endpackage : t1ra_pkg

// ===== sim/t1ra_line_src.sv
// partner model: receive line source feeding the alarm detectors
`timescale 1ns/100ps
module t1ra_line_src (
  input  wire logic                 clk,
  output      t1ra_pkg::t1ra_line_t line
);
  int nbits;
  initial begin
    line  = '0;
    nbits = 0;
  end
  // kind 0 bit, 1 channel bit 2, 2 twelfth f-bit, 3 link pattern
  // one strobe per unit and a gap cycle; idle data shows the inverse
  task automatic unit(input int kind, input logic v);
    @(posedge clk);
    case (kind)
      0: begin
        line.bit_en  <= 1'b1;
        line.bit_val <= v;
        nbits++;
      end
      1: begin
        line.ch_bit2_en <= 1'b1;
        line.ch_bit2    <= v;
      end
      2: begin
        line.fbit12_en <= 1'b1;
        line.fbit12    <= v;
      end
      default: begin
        line.fdl_en    <= 1'b1;
        line.fdl_match <= v;
      end
    endcase
    @(posedge clk);
    line.bit_en     <= 1'b0;
    line.ch_bit2_en <= 1'b0;
    line.fbit12_en  <= 1'b0;
    line.fdl_en     <= 1'b0;
    line.bit_val    <= ~v;
    line.ch_bit2    <= ~v;
    line.fbit12     <= ~v;
    line.fdl_match  <= ~v;
  endtask : unit
  task automatic set_sync(input logic lost);
    @(posedge clk);
    line.frame_lost <= lost;
  endtask : set_sync
endmodule : t1ra_line_src

// ===== sim/t1ra_top_tb_top.sv
// self-checking bench for the t1 receive alarm block
`timescale 1ns/100ps
module t1ra_top_tb_top;
  localparam logic [11:0] B  = 12'h200;
  localparam logic [11:0] LA = B + t1ra_pkg::OFF_LATCHED_1;
  localparam logic [11:0] MK = B + t1ra_pkg::OFF_MASK_1;
  localparam logic [11:0] RT = B + t1ra_pkg::OFF_REALTIME_1;
  localparam logic [11:0] CT = B + t1ra_pkg::OFF_RX_CTRL_2;
  logic                 clk, nrst, awvalid, wvalid, bready, arvalid, rready;
  logic                 awready, wready, bvalid, arready, rvalid, irq_out_n;
  logic [11:0]          awaddr, araddr;
  logic [31:0]          wdata, rdata, d;
  logic [3:0]           wstrb;
  logic [1:0]           bresp, rresp, r;
  logic [63:0]          pat;
  t1ra_pkg::t1ra_line_t line;
  int                   fail_count, checks;

  t1ra_line_src src (.clk(clk), .line(line));
  // second framer position, short blue window to keep the run brief
  t1ra_top #(.FRAMER_N(2), .BLUE_WIN(64)) dut (
    .clk(clk), .nrst(nrst), .line(line),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq_out_n(irq_out_n));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic run(input int kind, input int n, input logic v);
    repeat (n) src.unit(kind, v);
  endtask : run

  // random pattern with exactly z zeros among 64 bits
  function automatic logic [63:0] mkpat(input int z);
    logic [63:0] p;
    p = '1;
    while ($countones(~p) < z) p[$urandom_range(63, 0)] = 1'b0;
    return p;
  endfunction : mkpat

  function automatic logic blue_exp(input int z);
    return z < t1ra_pkg::BLUE_CLR_ZEROS;
  endfunction : blue_exp

  function automatic logic yel_d4(input int z);
    return z >= t1ra_pkg::YEL_D4_ZEROS;
  endfunction : yel_d4

  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    end_of_test();
  end

  initial begin
    int z;
    nrst = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = '0; araddr = '0;
    wdata = '0; wstrb = 4'hF; fail_count = 0; checks = 0;
    void'($urandom(32'hDE7C));
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    // reset values, framer offset, unmapped place, read-only place
    rd(LA); chk(d, 32'h0);
    rd(MK); chk(d, 32'h0);
    rd(12'h000); chk({30'h0, r}, {30'h0, t1ra_pkg::RESP_SLVERR});
    wr(RT, 32'hF); rd(RT); chk(d, 32'h0);
    wr(CT, 32'h3); rd(CT); chk(d, 32'h3);
    wr(CT, 32'h0);
    $display("test regs done");
    // frame loss, latches, mask and interrupt
    wr(MK, 32'h1);
    src.set_sync(1'b1);
    repeat (4) @(posedge clk);
    chk(irq_out_n, 1'b0);
    rd(RT); chk(d[0], 1'b1);
    rd(LA); chk(d, 32'h1);
    rd(LA); chk(d, 32'h1);
    wr(LA, 32'h0); rd(LA); chk(d, 32'h1);
    chk(irq_out_n, 1'b0);
    wr(LA, 32'h1); chk(irq_out_n, 1'b1);
    rd(LA); chk(d, 32'h0);
    repeat (8) @(posedge clk);
    rd(LA); chk(d, 32'h0);
    src.set_sync(1'b0);
    repeat (4) @(posedge clk);
    rd(RT); chk(d[0], 1'b0);
    rd(LA); chk(d, 32'h10);
    chk(irq_out_n, 1'b1);
    wr(LA, 32'hFF);
    $display("test frame done");
    // signal loss set and clear at the exact counts
    run(0, t1ra_pkg::LOS_SET_ZEROS - 1, 1'b0);
    rd(RT); chk(d[1], 1'b0);
    run(0, 1, 1'b0);
    rd(RT); chk(d[1], 1'b1);
    rd(LA); chk(d[1], 1'b1);
    run(0, t1ra_pkg::LOS_CLR_ONES - 1, 1'b1);
    rd(RT); chk(d[1], 1'b1);
    run(0, 1, 1'b1);
    rd(RT); chk(d[1], 1'b0);
    $display("test los done");
    // blue alarm on window boundaries, random zero positions
    while (src.nbits % 64 != 0) src.unit(0, 1'b1);
    for (int i = 0; i < 4; i++) begin
      z = (i == 3) ? 5 : $urandom_range(4, 0);
      pat = mkpat(z);
      for (int j = 0; j < 64; j++) src.unit(0, pat[j]);
      rd(RT); chk(d[2], blue_exp(z));
      chk(d[2] & ~d[0], blue_exp(z));
    end
    rd(RT); chk(d[2], 1'b0);
    $display("test blue done");
    // yellow, d4 bit 2 mode at both sides of the threshold
    for (int i = 0; i < 2; i++) begin
      z = 254 - i;
      run(1, 256 - z, 1'b1);
      run(1, z, 1'b0);
      rd(RT); chk(d[3], yel_d4(z));
    end
    // yellow, esf link patterns
    wr(CT, 32'h2);
    run(3, 15, 1'b1);
    rd(RT); chk(d[3], 1'b0);
    run(3, 1, 1'b1);
    rd(RT); chk(d[3], 1'b1);
    run(3, 15, 1'b1); run(3, 1, 1'b0);
    rd(RT); chk(d[3], 1'b1);
    run(3, 14, 1'b1); run(3, 2, 1'b0);
    rd(RT); chk(d[3], 1'b0);
    // yellow, d4 twelfth f-bit mode
    wr(CT, 32'h1);
    run(2, 1, 1'b1);
    rd(RT); chk(d[3], 1'b0);
    run(2, 1, 1'b1);
    rd(RT); chk(d[3], 1'b1);
    run(2, 1, 1'b0);
    rd(RT); chk(d[3], 1'b1);
    run(2, 1, 1'b0);
    rd(RT); chk(d[3], 1'b0);
    rd(LA); chk(d[7], 1'b1);
    $display("test yellow done");
    end_of_test();
  end
endmodule : t1ra_top_tb_top
